/* logic/imc_pkg.sv */
// constants for the interrupt mode control register, sources 52 to 55
package imc_pkg;
  localparam int IMC_NSRC = 4;
  localparam logic [31:0] IMC_REG_ADDR = 32'hFFFFE034;
  localparam logic [31:0] IMC_REG_RESET = 32'h00000000;
  localparam int IMC_LANE_W = 8;
  localparam int IMC_LVL_LSB = 0;
  localparam int IMC_DMA_BIT = 3;
  localparam int IMC_DET_LSB = 4;
  localparam logic [7:0] IMC_LANE_MASK = 8'h3F;
  localparam logic [2:0] IMC_LVL_OFF = 3'h0;
  localparam logic [2:0] IMC_CHAN_MAX = 3'h3;
endpackage : imc_pkg

/* logic/imc_mode_ctrl.sv */
// interrupt mode control register for sources 52 to 55 with routing
`timescale 1ns/10ps
// Operation
// - a set routing bit makes the request a dma start, else a cpu irq.
// - routing clear: field 000 disables, 001 to 111 give levels 1 to 7.
// - routing set: field picks dma channel 0 to 3, higher values invalid.
// - byte lanes hold sources 52 to 55 from the low byte up, six bits each.
module imc_mode_ctrl
  import imc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // source requests, bit 0 is source 52
  input wire logic [IMC_NSRC-1:0] src_req,
  // cpu side
  output logic [IMC_NSRC-1:0] cpu_irq,
  output logic [2:0] cpu_level [IMC_NSRC],
  // dma side
  output logic [IMC_NSRC-1:0] dma_start,
  output logic [1:0] dma_chan [IMC_NSRC],
  output logic [IMC_NSRC-1:0] dma_chan_bad
);

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] mode_reg;
  logic [31:0] next_mode_reg;
  wire logic hit = reg_addr == IMC_REG_ADDR;
  wire logic wr_hit = reg_wr && hit;
  wire logic rd_hit = reg_rd && hit;

  // each lane keeps only its six defined bits
  genvar g;
  generate
    for (g = 0; g < IMC_NSRC; g++)
    begin : g_lane
      assign next_mode_reg[g*IMC_LANE_W +: IMC_LANE_W] =
        reg_wdata[g*IMC_LANE_W +: IMC_LANE_W] & IMC_LANE_MASK;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_reg <= IMC_REG_RESET;
    else if (clk_en && wr_hit)
      mode_reg <= next_mode_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      reg_rdata <= 32'h00000000;
    else if (clk_en)
      reg_rdata <= rd_hit ? mode_reg : 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic lane_dma(input logic [7:0] lane);
    lane_dma = lane[IMC_DMA_BIT];
  endfunction : lane_dma

  function automatic logic [2:0] lane_lvl(input logic [7:0] lane);
    lane_lvl = lane[IMC_LVL_LSB +: 3];
  endfunction : lane_lvl

  logic [IMC_NSRC-1:0] next_cpu_irq;
  logic [IMC_NSRC-1:0] next_dma_start;
  logic [IMC_NSRC-1:0] next_bad;

  generate
    for (g = 0; g < IMC_NSRC; g++)
    begin : g_route
      wire logic [7:0] lane = mode_reg[g*IMC_LANE_W +: IMC_LANE_W];
      wire logic to_dma = lane_dma(lane);
      wire logic [2:0] lvl = lane_lvl(lane);
      // level 000 masks the cpu request
      assign next_cpu_irq[g] = src_req[g] && !to_dma && lvl != IMC_LVL_OFF;
      // invalid channel values start nothing
      assign next_bad[g] = to_dma && lvl > IMC_CHAN_MAX;
      assign next_dma_start[g] = src_req[g] && to_dma && !next_bad[g];
      always_ff @(posedge core_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          cpu_level[g] <= 3'h0;
          dma_chan[g] <= 2'h0;
        end
        else if (clk_en)
        begin
          cpu_level[g] <= to_dma ? 3'h0 : lvl;
          dma_chan[g] <= lvl[1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_irq <= '0;
      dma_start <= '0;
      dma_chan_bad <= '0;
    end
    else if (clk_en)
    begin
      cpu_irq <= next_cpu_irq;
      dma_start <= next_dma_start;
      dma_chan_bad <= next_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register port
  reg_write_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && wr_hit |=> mode_reg == ($past(reg_wdata) & 32'h3F3F3F3F))
    else $error("register write not stored");
  reg_read_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && rd_hit |=> reg_rdata == $past(mode_reg))
    else $error("read data wrong");
  read_idle_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !rd_hit |=> reg_rdata == 32'h00000000)
    else $error("read data left standing");
  write_miss_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !wr_hit |=> $stable(mode_reg))
    else $error("register changed without write");
  reserved_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (reg_rdata & 32'hC0C0C0C0) == 32'h00000000)
    else $error("reserved bits read nonzero");
  clk_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !clk_en |=> $stable(mode_reg) && $stable(reg_rdata)
    && $stable(cpu_irq) && $stable(dma_start))
    else $error("state moved while clock enable low");

  // routing to cpu or dma
  no_both_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !(|(cpu_irq & dma_start)))
    else $error("request routed twice");
  idle_quiet_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req == 4'h0 |=> cpu_irq == 4'h0 && dma_start == 4'h0)
    else $error("output without request");
  dma_route0_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[0] && mode_reg[3] && mode_reg[2:0] <= 3'h3
    |=> dma_start[0] && !cpu_irq[0])
    else $error("source 52 dma start missing");
  dma_route1_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[1] && mode_reg[11] && mode_reg[10:8] <= 3'h3
    |=> dma_start[1] && !cpu_irq[1])
    else $error("source 53 dma start missing");
  dma_route2_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[2] && mode_reg[19] && mode_reg[18:16] <= 3'h3
    |=> dma_start[2] && !cpu_irq[2])
    else $error("source 54 dma start missing");
  dma_route3_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[3] && mode_reg[27] && mode_reg[26:24] <= 3'h3
    |=> dma_start[3] && !cpu_irq[3])
    else $error("source 55 dma start missing");

  // priority levels
  cpu_route0_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[0] && !mode_reg[3] && mode_reg[2:0] != 3'h0
    |=> cpu_irq[0] && cpu_level[0] == $past(mode_reg[2:0]))
    else $error("source 52 cpu request wrong");
  cpu_route1_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[1] && !mode_reg[11] && mode_reg[10:8] != 3'h0
    |=> cpu_irq[1] && cpu_level[1] == $past(mode_reg[10:8]))
    else $error("source 53 cpu request wrong");
  cpu_route2_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[2] && !mode_reg[19] && mode_reg[18:16] != 3'h0
    |=> cpu_irq[2] && cpu_level[2] == $past(mode_reg[18:16]))
    else $error("source 54 cpu request wrong");
  cpu_route3_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && src_req[3] && !mode_reg[27] && mode_reg[26:24] != 3'h0
    |=> cpu_irq[3] && cpu_level[3] == $past(mode_reg[26:24]))
    else $error("source 55 cpu request wrong");
  lvl_off0_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !mode_reg[3] && mode_reg[2:0] == 3'h0 |=> !cpu_irq[0])
    else $error("disabled source 52 raised");
  lvl_off1_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !mode_reg[11] && mode_reg[10:8] == 3'h0 |=> !cpu_irq[1])
    else $error("disabled source 53 raised");
  lvl_off2_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !mode_reg[19] && mode_reg[18:16] == 3'h0 |=> !cpu_irq[2])
    else $error("disabled source 54 raised");
  lvl_off3_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !mode_reg[27] && mode_reg[26:24] == 3'h0 |=> !cpu_irq[3])
    else $error("disabled source 55 raised");
  dma_level_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[3] |=> cpu_level[0] == 3'h0)
    else $error("level shown for dma source");

  // dma channel select
  chan_sel0_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[3] |=> dma_chan[0] == $past(mode_reg[1:0]))
    else $error("source 52 channel wrong");
  chan_sel1_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[11] |=> dma_chan[1] == $past(mode_reg[9:8]))
    else $error("source 53 channel wrong");
  chan_sel2_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[19] |=> dma_chan[2] == $past(mode_reg[17:16]))
    else $error("source 54 channel wrong");
  chan_sel3_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[27] |=> dma_chan[3] == $past(mode_reg[25:24]))
    else $error("source 55 channel wrong");
  chan_bad0_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[3] && mode_reg[2]
    |=> dma_chan_bad[0] && !dma_start[0])
    else $error("invalid channel started on source 52");
  chan_bad1_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[11] && mode_reg[10]
    |=> dma_chan_bad[1] && !dma_start[1])
    else $error("invalid channel started on source 53");
  chan_bad2_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[19] && mode_reg[18]
    |=> dma_chan_bad[2] && !dma_start[2])
    else $error("invalid channel started on source 54");
  chan_bad3_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && mode_reg[27] && mode_reg[26]
    |=> dma_chan_bad[3] && !dma_start[3])
    else $error("invalid channel started on source 55");

endmodule : imc_mode_ctrl

/* test/imc_far_end.sv */
// far side model: cpu core and dma controller taking routed requests
`timescale 1ns/10ps
module imc_far_end
  import imc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // routed requests
  input wire logic [IMC_NSRC-1:0] cpu_irq,
  input wire logic [IMC_NSRC-1:0] dma_start,
  // requests seen one cycle later
  output logic [IMC_NSRC-1:0] taken
);
  // takes every cpu interrupt or dma start on the next clock edge
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      taken <= '0;
    else
      taken <= cpu_irq | dma_start;
endmodule : imc_far_end

/* test/testbench.sv */
// self-checking bench for the mode control register
`timescale 1ns/10ps
`define CHK(n,e,a) begin num_checks++; if ((a) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench import imc_pkg::*;;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, clk_en = 1;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic [3:0] src_req = '0, cpu_irq, dma_start, dma_chan_bad, taken;
  logic [2:0] cpu_level [IMC_NSRC];
  logic [1:0] dma_chan [IMC_NSRC];
  int bad_count = 0, num_checks = 0;
  initial forever #20 core_clk = ~core_clk;
  imc_mode_ctrl u_dut (.core_clk, .rst_b, .clk_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_req, .cpu_irq,
    .cpu_level, .dma_start, .dma_chan, .dma_chan_bad);
  imc_far_end u_far (.core_clk, .rst_b, .cpu_irq, .dma_start, .taken);
  task automatic wr_at(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr_at
  task automatic wr(input logic [31:0] d);
    wr_at(IMC_REG_ADDR, d);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
  endtask : rd
  task automatic req(input logic [3:0] r);
    @(posedge core_clk);
    src_req <= r;
    @(posedge core_clk);
    #1;
  endtask : req
  task automatic t_regs;
    rd(IMC_REG_ADDR, IMC_REG_RESET);
    wr('1);
    rd(IMC_REG_ADDR, 32'h3F3F3F3F);
    @(posedge core_clk);
    #1;
    `CHK("reg_rdata idle", 32'h00000000, reg_rdata)
    wr_at(32'hFFFFE038, 32'h00000000);
    rd(IMC_REG_ADDR, 32'h3F3F3F3F);
    rd(32'hFFFFE038, 32'h00000000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_cpu;
    for (int lv = 0; lv < 8; lv++)
    begin
      wr({4{8'h30 | 8'(lv)}});
      req(4'hF);
      `CHK("cpu_irq", (lv != 0) ? 4'hF : 4'h0, cpu_irq)
      `CHK("cpu_level", 3'(lv), cpu_level[2])
      `CHK("dma_start", 4'h0, dma_start)
    end
    $display("test cpu done");
  endtask : t_cpu
  task automatic t_dma;
    for (int ch = 0; ch < 8; ch++)
    begin
      wr({4{8'h38 | 8'(ch)}});
      req(4'hF);
      `CHK("dma_start", (ch < 4) ? 4'hF : 4'h0, dma_start)
      `CHK("dma_chan", 2'(ch), dma_chan[1])
      `CHK("dma_chan_bad", (ch > 3) ? 4'hF : 4'h0, dma_chan_bad)
      `CHK("cpu_irq", 4'h0, cpu_irq)
    end
    $display("test dma done");
  endtask : t_dma
  task automatic t_lane;
    wr(32'h38303A31);
    req(4'hF);
    `CHK("cpu_irq", 4'h1, cpu_irq)
    `CHK("dma_start", 4'hA, dma_start)
    `CHK("dma_chan", 2'h2, dma_chan[1])
    @(posedge core_clk);
    #1;
    `CHK("taken", 4'hB, taken)
    req(4'h0);
    `CHK("dma_start", 4'h0, dma_start)
    $display("test lanes done");
  endtask : t_lane
  task automatic t_hold;
    @(posedge core_clk);
    clk_en <= 1'b0;
    src_req <= 4'hF;
    wr(32'h31313131);
    #1;
    `CHK("held cpu_irq", 4'h0, cpu_irq)
    `CHK("held dma_start", 4'h0, dma_start)
    @(posedge core_clk);
    clk_en <= 1'b1;
    rd(IMC_REG_ADDR, 32'h38303A31);
    `CHK("cpu_irq", 4'h1, cpu_irq)
    `CHK("dma_start", 4'hA, dma_start)
    $display("test hold done");
  endtask : t_hold
  task automatic t_reset;
    @(posedge core_clk);
    rst_b <= 1'b0;
    @(posedge core_clk);
    #1;
    `CHK("reset cpu_irq", 4'h0, cpu_irq)
    `CHK("reset cpu_level", 3'h0, cpu_level[0])
    @(posedge core_clk);
    rst_b <= 1'b1;
    rd(IMC_REG_ADDR, IMC_REG_RESET);
    `CHK("cpu_irq", 4'h0, cpu_irq)
    $display("test reset done");
  endtask : t_reset
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_regs();
    t_cpu();
    t_dma();
    t_lane();
    t_hold();
    t_reset();
    results();
  end
endmodule : testbench
